// >>> rtl/wss_servant.sv
`timescale 1ns/1ps
`default_nettype none
module wss_servant
	import wss_pkg::*;
#(
	parameter logic [15:0] IDENT_CODE = WSS_IDENT_DEF,
	parameter logic [15:0] KIND_CODE  = WSS_KIND_DEF,
	parameter longint      READY_CYC  = WSS_READY_CYC
)(
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic [7:0]    log_addr,
	input  wire logic          bus_as_n,
	input  wire logic          bus_ds_n,
	input  wire logic          bus_write_n,
	input  wire logic [5:0]    bus_am,
	input  wire logic [15:1]   bus_addr,
	input  wire logic [15:0]   bus_data_in,
	output logic     [15:0]    bus_data_out,
	output logic               bus_data_oe_n,
	output logic               bus_dtack_n,
	output logic               bus_berr_n,
	output logic     [7:0]     cmd_byte,
	output logic               cmd_end,
	output logic               cmd_valid,
	input  wire logic          cmd_ready,
	output logic               cmd_line_done,
	input  wire logic [7:0]    rsp_byte,
	input  wire logic          rsp_valid,
	output logic               rsp_ready,
	output logic               rsp_request,
	output logic               soft_reset
);
	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [1:0]  as_s_r;
	logic [1:0]  ds_s_r;
	logic [1:0]  wr_s_r;
	logic [5:0]  am_s1_r;
	logic [5:0]  am_s2_r;
	logic [15:1] a_s1_r;
	logic [15:1] a_s2_r;
	logic [15:0] d_s1_r;
	logic [15:0] d_s2_r;
	logic [7:0]  la_s1_r;
	logic [7:0]  la_s2_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			as_s_r <= 2'b11;
			ds_s_r <= 2'b11;
			wr_s_r <= 2'b11;
		end else begin
			as_s_r <= {as_s_r[0], bus_as_n};
			ds_s_r <= {ds_s_r[0], bus_ds_n};
			wr_s_r <= {wr_s_r[0], bus_write_n};
		end
	end

	always_ff @(posedge clk) begin
		am_s1_r <= bus_am;
		am_s2_r <= am_s1_r;
		a_s1_r  <= bus_addr;
		a_s2_r  <= a_s1_r;
		d_s1_r  <= bus_data_in;
		d_s2_r  <= d_s1_r;
		la_s1_r <= log_addr;
		la_s2_r <= la_s1_r;
	end

	// ************************************************************
	// Soft reset and ready timer
	// ************************************************************
	logic        srst_r;
	logic        irst;
	logic [31:0] rdy_cnt_r;
	logic        ready_r;
	logic        ctl_wr;

	assign irst       = rst || srst_r;
	assign soft_reset = srst_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			srst_r <= 1'b0;
		end else begin
			srst_r <= ctl_wr && d_s2_r[WSS_CTL_RESET_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (irst) begin
			rdy_cnt_r <= 32'd0;
			ready_r   <= 1'b0;
		end else if (64'(rdy_cnt_r) >= 64'(READY_CYC) - 64'd1) begin
			ready_r   <= 1'b1;
		end else begin
			rdy_cnt_r <= rdy_cnt_r + 32'd1;
		end
	end

	// ************************************************************
	// Address decode
	// ************************************************************
	logic [15:0] base;
	logic        sel;
	logic        strobe;
	logic        busy_r;
	logic [5:0]  off;
	logic        is_wr;

	assign base   = WSS_BLOCK_BASE + 16'(la_s2_r) * WSS_BLOCK_STRIDE;
	assign off    = {a_s2_r[5:1], 1'b0};
	assign sel    = (am_s2_r == 6'h29 || am_s2_r == 6'h2D)
		&& ({a_s2_r[15:6], 6'h00} == base);
	assign strobe = !as_s_r[1] && !ds_s_r[1] && sel && !busy_r;
	assign is_wr  = !wr_s_r[1];
	assign ctl_wr = strobe && is_wr && off == WSS_OFF_STATCTL;

	// ************************************************************
	// Command path
	// ************************************************************
	wss_stream_if cmd_in ();
	wss_stream_if cmd_out ();
	logic bav_wr;
	logic req_wr;

	assign bav_wr = strobe && is_wr && off == WSS_OFF_LOWER && ready_r
		&& (d_s2_r[15:8] == WSS_CMD_BAV || d_s2_r[15:8] == WSS_CMD_BAV_END);
	assign req_wr = strobe && is_wr && off == WSS_OFF_LOWER && ready_r
		&& d_s2_r == WSS_CMD_BYTE_REQ;

	assign cmd_in.valid = bav_wr && cmd_in.ready;
	assign cmd_in.data  = {d_s2_r[8], d_s2_r[7:0]};

	wss_skid_buf u_buf (
		.clk (clk),
		.rst (irst),
		.up  (cmd_in),
		.dn  (cmd_out)
	);

	assign cmd_valid     = cmd_out.valid;
	assign cmd_byte      = cmd_out.data[7:0];
	assign cmd_end       = cmd_out.data[8];
	assign cmd_out.ready = cmd_ready;
	assign cmd_line_done = cmd_out.valid && cmd_ready
		&& (cmd_out.data[8] || cmd_out.data[7:0] == WSS_LINE_FEED);

	// ************************************************************
	// Response path
	// ************************************************************
	wss_rd_e    rd_st_r;
	logic [7:0] rsp_r;
	logic       rd_low;
	logic       dir;

	assign rd_low      = strobe && !is_wr && off == WSS_OFF_LOWER;
	assign rsp_ready   = (rd_st_r == WSS_RD_WAIT);
	assign rsp_request = req_wr && rd_st_r == WSS_RD_IDLE;
	assign dir         = cmd_in.ready;

	always_ff @(posedge clk) begin
		if (irst) begin
			rd_st_r <= WSS_RD_IDLE;
			rsp_r   <= 8'h00;
		end else begin
			case (rd_st_r)
				WSS_RD_IDLE: begin
					if (rsp_request) begin
						rd_st_r <= WSS_RD_WAIT;
					end
				end
				WSS_RD_WAIT: begin
					if (rsp_valid) begin
						rsp_r   <= rsp_byte;
						rd_st_r <= WSS_RD_FULL;
					end
				end
				WSS_RD_FULL: begin
					if (rd_low) begin
						rd_st_r <= WSS_RD_IDLE;
					end
				end
				default: begin
					rd_st_r <= WSS_RD_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Register read mux and bus answer
	// ************************************************************
	logic [15:0] flags;
	logic [15:0] status;
	logic        wrdy;
	logic        rrdy;
	logic        dor;

	assign wrdy = ready_r && rd_st_r == WSS_RD_IDLE;
	assign rrdy = rd_st_r == WSS_RD_FULL;
	assign dor  = ready_r && rd_st_r != WSS_RD_WAIT;

	always_comb begin
		flags = WSS_RSP_BASE;
		flags[WSS_RSP_DOR_BIT]  = dor;
		flags[WSS_RSP_DIR_BIT]  = dir && ready_r;
		flags[WSS_RSP_WRDY_BIT] = wrdy;
		flags[WSS_RSP_RRDY_BIT] = rrdy;
		status = WSS_ST_BASE;
		status[WSS_ST_READY_BIT]  = ready_r;
		status[WSS_ST_PASSED_BIT] = ready_r;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			busy_r        <= 1'b0;
			bus_dtack_n   <= 1'b1;
			bus_berr_n    <= 1'b1;
			bus_data_oe_n <= 1'b1;
			bus_data_out  <= 16'h0000;
		end else if (busy_r) begin
			if (as_s_r[1] || ds_s_r[1]) begin
				busy_r        <= 1'b0;
				bus_dtack_n   <= 1'b1;
				bus_berr_n    <= 1'b1;
				bus_data_oe_n <= 1'b1;
			end
		end else if (strobe) begin
			busy_r <= 1'b1;
			if (rd_low && rd_st_r != WSS_RD_FULL) begin
				bus_berr_n <= 1'b0;
			end else begin
				bus_dtack_n <= 1'b0;
				if (!is_wr) begin
					bus_data_oe_n <= 1'b0;
					if (off == WSS_OFF_IDENT) begin
						bus_data_out <= IDENT_CODE;
					end else if (off == WSS_OFF_KIND) begin
						bus_data_out <= KIND_CODE;
					end else if (off == WSS_OFF_STATCTL) begin
						bus_data_out <= status;
					end else if (off == WSS_OFF_CAPAB) begin
						bus_data_out <= WSS_CAPAB_VAL;
					end else if (off == WSS_OFF_FLAGS) begin
						bus_data_out <= flags;
					end else if (off == WSS_OFF_LOWER) begin
						bus_data_out <= {8'hFF, rsp_r};
					end else begin
						bus_data_out <= 16'h0000;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/wss_pkg.sv
package wss_pkg;

	// ************************************************************
	// Address map
	// ************************************************************
	localparam logic [15:0] WSS_BLOCK_BASE     = 16'hC000;
	localparam logic [15:0] WSS_BLOCK_STRIDE   = 16'h0040;
	localparam int          WSS_OFF_W          = 6;
	localparam int          WSS_LA_W           = 8;
	localparam logic [5:0]  WSS_OFF_IDENT      = 6'h00;
	localparam logic [5:0]  WSS_OFF_KIND       = 6'h02;
	localparam logic [5:0]  WSS_OFF_STATCTL    = 6'h04;
	localparam logic [5:0]  WSS_OFF_UNUSED     = 6'h06;
	localparam logic [5:0]  WSS_OFF_CAPAB      = 6'h08;
	localparam logic [5:0]  WSS_OFF_FLAGS      = 6'h0A;
	localparam logic [5:0]  WSS_OFF_UPPER      = 6'h0C;
	localparam logic [5:0]  WSS_OFF_LOWER      = 6'h0E;

	// ************************************************************
	// Constant register values
	// ************************************************************
	localparam logic [15:0] WSS_CAPAB_VAL      = 16'hF7FF;
	localparam logic [15:0] WSS_IDENT_DEF      = 16'h1234;
	localparam logic [15:0] WSS_KIND_DEF       = 16'h5678;

	// ************************************************************
	// Word serial commands
	// ************************************************************
	localparam logic [15:0] WSS_CMD_BYTE_REQ   = 16'hDEFF;
	localparam logic [7:0]  WSS_CMD_BAV        = 8'hBC;
	localparam logic [7:0]  WSS_CMD_BAV_END    = 8'hBD;
	localparam logic [7:0]  WSS_LINE_FEED      = 8'h0A;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int          WSS_CTL_RESET_BIT  = 0;
	localparam int          WSS_ST_READY_BIT   = 3;
	localparam int          WSS_ST_PASSED_BIT  = 2;
	localparam int          WSS_RSP_DOR_BIT    = 13;
	localparam int          WSS_RSP_DIR_BIT    = 12;
	localparam int          WSS_RSP_WRDY_BIT   = 10;
	localparam int          WSS_RSP_RRDY_BIT   = 11;
	localparam logic [15:0] WSS_RSP_BASE       = 16'h8000;
	localparam logic [15:0] WSS_ST_BASE        = 16'h4000;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int          WSS_CLK_MHZ        = 250;
	localparam int          WSS_READY_TIME_S   = 5;
	localparam longint      WSS_READY_CYC      = longint'(WSS_READY_TIME_S) * WSS_CLK_MHZ * 1000000;

	typedef enum logic [1:0] {
		WSS_RD_IDLE = 2'b00,
		WSS_RD_WAIT = 2'b01,
		WSS_RD_FULL = 2'b11
	} wss_rd_e;

endpackage

// >>> rtl/wss_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wss_stream_if;
	logic       valid;
	logic       ready;
	logic [8:0] data;
	modport src (output valid, output data, input ready);
	modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> rtl/wss_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none
module wss_skid_buf
	import wss_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   rst,
	wss_stream_if.dst   up,
	wss_stream_if.src   dn
);
	// ************************************************************
	// Two-entry buffer
	// ************************************************************
	logic [8:0] mem_r [2];
	logic       wp_r;
	logic       rp_r;
	logic [1:0] cnt_r;
	logic       push;
	logic       pop;

	assign up.ready = (cnt_r != 2'd2);
	assign dn.valid = (cnt_r != 2'd0);
	assign dn.data  = mem_r[rp_r];
	assign push     = up.valid && up.ready;
	assign pop      = dn.valid && dn.ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wp_r] <= up.data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wp_r  <= 1'b0;
			rp_r  <= 1'b0;
			cnt_r <= 2'd0;
		end else begin
			if (push) begin
				wp_r <= ~wp_r;
			end
			if (pop) begin
				rp_r <= ~rp_r;
			end
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
`default_nettype wire

// >>> sim/wss_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module wss_assertions
	import wss_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        bus_as_n,
	input  wire logic        bus_ds_n,
	input  wire logic        bus_write_n,
	input  wire logic [15:1] bus_addr,
	input  wire logic [15:0] bus_data_in,
	input  wire logic [15:0] bus_data_out,
	input  wire logic        bus_data_oe_n,
	input  wire logic        bus_dtack_n,
	input  wire logic        bus_berr_n,
	input  wire logic [7:0]  cmd_byte,
	input  wire logic        cmd_end,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_ready,
	input  wire logic        cmd_line_done,
	input  wire logic        rsp_request,
	input  wire logic        soft_reset
);
	// ********
	// Checks
	// ********
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence ack_s;
		$fell(bus_dtack_n);
	endsequence
	sequence wr_s(o);
		ack_s ##0 !bus_write_n && bus_addr[5:1] == o;
	endsequence
	one_answer_a: assert property (!(!bus_dtack_n && !bus_berr_n))
		else $error("dtack and berr both low");
	answer_cause_a: assert property (($fell(bus_dtack_n) || $fell(bus_berr_n)) |-> $past(!bus_as_n && !bus_ds_n, 2))
		else $error("answer without strobes");
	answer_release_a: assert property (bus_ds_n [*6] |-> bus_dtack_n && bus_berr_n)
		else $error("answer held after strobe release");
	capab_read_a: assert property (ack_s ##0 bus_write_n && bus_addr[5:1] == 5'h04 |-> bus_data_out == WSS_CAPAB_VAL)
		else $error("capability word wrong");
	soft_pulse_a: assert property (wr_s(5'h02) ##0 bus_data_in[0] |-> ##[0:2] soft_reset)
		else $error("no soft reset pulse");
	byte_req_a: assert property (wr_s(5'h07) ##0 bus_data_in == WSS_CMD_BYTE_REQ |-> $past(rsp_request))
		else $error("byte request not passed on");
	read_drive_a: assert property (ack_s ##0 bus_write_n |-> !bus_data_oe_n)
		else $error("read data not driven");
	line_end_a: assert property (cmd_valid && cmd_ready && (cmd_end || cmd_byte == WSS_LINE_FEED) |-> ##[0:1] cmd_line_done)
		else $error("no line done");
	cmd_hold_a: assert property (cmd_valid && !cmd_ready && !soft_reset |=> soft_reset || cmd_valid && $stable(cmd_byte))
		else $error("command byte lost");
endmodule
bind wss_servant wss_assertions i_chk (.clk(clk), .rst(rst), .bus_as_n(bus_as_n), .bus_ds_n(bus_ds_n),
	.bus_write_n(bus_write_n), .bus_addr(bus_addr), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
	.bus_dtack_n(bus_dtack_n), .bus_berr_n(bus_berr_n), .cmd_byte(cmd_byte), .cmd_end(cmd_end),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_line_done(cmd_line_done),
	.rsp_request(rsp_request), .soft_reset(soft_reset), .bus_data_oe_n(bus_data_oe_n));
`default_nettype wire

// >>> sim/wss_commander.sv
`timescale 1ns/1ps
`default_nettype none
module wss_commander (
	input  wire logic        clk,
	input  wire logic        dtack_n,
	input  wire logic        berr_n,
	input  wire logic [15:0] dout,
	output logic             as_n,
	output logic             ds_n,
	output logic             write_n,
	output logic [5:0]       am,
	output logic [15:1]      addr,
	output logic [15:0]      din
);
	// ********
	// Bus cycle
	// ********
	initial begin
		as_n = 1'b1;
		ds_n = 1'b1;
		write_n = 1'b1;
		am = 6'h29;
		addr = '0;
		din = '0;
	end
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] wd,
		input logic [5:0] m, output logic [15:0] rd, output int ans);
		int n;
		@(posedge clk);
		am <= m;
		addr <= a[15:1];
		din <= wd;
		write_n <= !w;
		as_n <= 1'b0;
		ds_n <= 1'b0;
		ans = 0;
		for (n = 0; n < 40 && ans == 0; n++) begin
			@(posedge clk);
			if (dtack_n === 1'b0) ans = 1;
			else if (berr_n === 1'b0) ans = 2;
		end
		rd = dout;
		as_n <= 1'b1;
		ds_n <= 1'b1;
		addr <= ~addr;
		din <= ~din;
		for (n = 0; n < 20 && !(dtack_n && berr_n); n++) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// >>> sim/tb_word_serial_servant_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_word_serial_servant_port;
	import wss_pkg::*;
	// ********
	// Bench
	// ********
	localparam logic [15:0] KDC  = 16'h3B6D; // Arbitrary value
	localparam logic [7:0]  LA   = 8'h05;
	localparam logic [15:0] BASE = WSS_BLOCK_BASE + 16'(LA) * WSS_BLOCK_STRIDE;
	logic        clk;
	logic        rst = 1'b1;
	logic        cmd_ready = 1'b0;
	logic        rsp_valid = 1'b0;
	logic        rsp_en = 1'b0;
	logic [7:0]  rsp_byte = 8'h00;
	logic        as_n, ds_n, wr_n, dtack_n, berr_n, cmd_valid, cmd_end, line_done, rsp_ready;
	logic [5:0]  am;
	logic [15:1] addr;
	logic [15:0] din, dout, rd;
	logic [7:0]  cmd_byte;
	logic [8:0]  got[$];
	int          ans, lines, failures, tests_run;
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	wss_commander i_cmd (.clk(clk), .dtack_n(dtack_n), .berr_n(berr_n), .dout(dout), .as_n(as_n),
		.ds_n(ds_n), .write_n(wr_n), .am(am), .addr(addr), .din(din));
	wss_servant #(.KIND_CODE(KDC), .READY_CYC(20)) i_dut (.clk(clk), .rst(rst), .log_addr(LA),
		.bus_as_n(as_n), .bus_ds_n(ds_n), .bus_write_n(wr_n), .bus_am(am), .bus_addr(addr),
		.bus_data_in(din), .bus_data_out(dout), .bus_data_oe_n(), .bus_dtack_n(dtack_n),
		.bus_berr_n(berr_n), .cmd_byte(cmd_byte), .cmd_end(cmd_end), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_line_done(line_done), .rsp_byte(rsp_byte), .rsp_valid(rsp_valid),
		.rsp_ready(rsp_ready), .rsp_request(), .soft_reset());
	always @(posedge clk) begin
		rsp_valid <= rsp_en && rsp_ready && !rsp_valid;
		if (cmd_valid && cmd_ready) got.push_back({cmd_end, cmd_byte});
		if (line_done) lines++;
	end
	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s exp %h got %h", name, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [5:0] o, input logic [15:0] wd);
		i_cmd.acc(w, BASE + 16'(o), wd, 6'h29, rd, ans);
	endtask
	task automatic poll(input logic [15:0] m);
		int n = 0;
		do begin
			acc(1'b0, WSS_OFF_FLAGS, 16'h0000);
			n++;
		end while (n < 60 && (rd & m) !== m);
		chk("poll", m, rd & m);
	endtask
	task automatic s_regs;
		acc(1'b0, WSS_OFF_FLAGS, 16'h0000);
		chk("dir early", 16'h0000, rd & 16'h1000);
		repeat (30) @(posedge clk);
		acc(1'b1, WSS_OFF_CAPAB, 16'h0000);
		acc(1'b0, WSS_OFF_CAPAB, 16'h0000);
		chk("capab", WSS_CAPAB_VAL, rd);
		acc(1'b0, WSS_OFF_KIND, 16'h0000);
		chk("kind", KDC, rd);
		acc(1'b0, WSS_OFF_STATCTL, 16'h0000);
		chk("status", 16'h000C, rd & 16'h000C);
		acc(1'b0, WSS_OFF_FLAGS, 16'h0000);
		chk("flags", 16'hB400, rd & 16'hBC00);
		i_cmd.acc(1'b0, BASE + 16'h0040, 16'h0000, 6'h29, rd, ans);
		chk("outside", 16'h0000, 16'(ans));
		i_cmd.acc(1'b0, BASE + 16'(WSS_OFF_CAPAB), 16'h0000, 6'h39, rd, ans);
		chk("a24", 16'h0000, 16'(ans));
	endtask
	task automatic s_write;
		poll(16'h1400);
		acc(1'b1, WSS_OFF_LOWER, 16'hBC41);
		acc(1'b1, WSS_OFF_LOWER, 16'hBD42);
		acc(1'b1, WSS_OFF_LOWER, 16'hBC43);
		acc(1'b0, WSS_OFF_FLAGS, 16'h0000);
		chk("dir full", 16'h0000, rd & 16'h1000);
		chk("head", 16'h0041, {7'h00, cmd_end, cmd_byte});
		cmd_ready <= 1'b1;
		poll(16'h1000);
		chk("count", 16'h0002, 16'(got.size()));
		chk("second", 16'h0142, 16'(got[1]));
		acc(1'b1, WSS_OFF_LOWER, 16'hBC0A);
		repeat (8) @(posedge clk);
		chk("lines", 16'h0002, 16'(lines));
	endtask
	task automatic s_read;
		rsp_byte <= 8'h5A;
		poll(16'h2400);
		acc(1'b1, WSS_OFF_LOWER, WSS_CMD_BYTE_REQ);
		acc(1'b0, WSS_OFF_FLAGS, 16'h0000);
		chk("dor wait", 16'h0000, rd & 16'h2000);
		rsp_en <= 1'b1;
		poll(16'h2800);
		acc(1'b0, WSS_OFF_LOWER, 16'h0000);
		chk("byte", 16'hFF5A, rd);
	endtask
	task automatic s_fast;
		rsp_byte <= 8'hC3;
		acc(1'b1, WSS_OFF_LOWER, WSS_CMD_BYTE_REQ);
		acc(1'b0, WSS_OFF_LOWER, 16'h0000);
		chk("fast", 16'hFFC3, rd);
		rsp_en <= 1'b0;
		acc(1'b1, WSS_OFF_LOWER, WSS_CMD_BYTE_REQ);
		acc(1'b0, WSS_OFF_LOWER, 16'h0000);
		chk("berr", 16'h0002, 16'(ans));
		rsp_en <= 1'b1;
		poll(16'h2800);
		acc(1'b0, WSS_OFF_LOWER, 16'h0000);
		chk("late", 16'hFFC3, rd);
	endtask
	task automatic s_soft;
		acc(1'b1, WSS_OFF_STATCTL, 16'h0001);
		acc(1'b0, WSS_OFF_FLAGS, 16'h0000);
		chk("dir soft", 16'h0000, rd & 16'h1000);
		poll(16'h1400);
	endtask
	task automatic report_and_stop;
		if (failures == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		s_regs;
		s_write;
		s_read;
		s_fast;
		s_soft;
		report_and_stop;
	end
	initial begin
		#80000;
		failures++;
		report_and_stop;
	end
endmodule
`default_nettype wire
